// File: amlt_chk.sv
// Checker for the configuration bank: bus answer timing, match result flags and lock flags.
// Assumes it is bound to amlt_top and sees only that module's ports.
`timescale 1ns/100ps
module amlt_chk (
  // Clock and reset.
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  // Bus.
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Packet and lock.
  input wire logic        PKT_START,
  input wire logic        PKT_VALID,
  input wire logic        PKT_LAST,
  input wire logic        MATCH_DONE,
  input wire logic        RX_ENTER,
  input wire logic        TX_ENTER,
  input wire logic        CAL_DONE,
  input wire logic        SYNTH_LOCKED,
  input wire logic        LOCK_MODE_TX
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // Bus phases; the slave adds exactly one wait state after the access phase starts.
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence access_s;
    PSEL && PENABLE && !PREADY;
  endsequence

  bus_answer_a: assert property (setup_s ##1 access_s |=> PREADY)
    else $error("No answer one cycle after the access phase.");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("Ready stood longer than one cycle.");
  ready_cause_a: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("Ready without an access phase.");
  unmapped_err_a: assert property (access_s and PADDR[11:2] < 10'h128 |=> PREADY && PSLVERR)
    else $error("Unmapped access gave no error.");
  // Match result is a level that only a new packet clears.
  match_done_a: assert property (PKT_VALID && PKT_LAST && !PKT_START |=> MATCH_DONE)
    else $error("Last byte gave no match result.");
  match_hold_a: assert property (MATCH_DONE && !PKT_START |=> MATCH_DONE)
    else $error("Match result dropped early.");
  match_clear_a: assert property (PKT_START && !PKT_VALID |=> !MATCH_DONE)
    else $error("New packet kept the old result.");
  // The wait must not finish while calibration is still outstanding.
  cal_first_a: assert property ((RX_ENTER || TX_ENTER) ##1 (!CAL_DONE) [*8] |-> !SYNTH_LOCKED)
    else $error("Lock before calibration completed.");
  tx_mode_a: assert property (TX_ENTER |=> LOCK_MODE_TX && !SYNTH_LOCKED)
    else $error("Transmit entry not recorded.");
  rx_mode_a: assert property (RX_ENTER && !TX_ENTER |=> !LOCK_MODE_TX && !SYNTH_LOCKED)
    else $error("Receive entry not recorded.");
endmodule

bind amlt_top amlt_chk chk_u (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PKT_START(PKT_START), .PKT_VALID(PKT_VALID),
  .PKT_LAST(PKT_LAST), .MATCH_DONE(MATCH_DONE), .RX_ENTER(RX_ENTER), .TX_ENTER(TX_ENTER),
  .CAL_DONE(CAL_DONE), .SYNTH_LOCKED(SYNTH_LOCKED), .LOCK_MODE_TX(LOCK_MODE_TX)
);

// File: amlt_lock_timer.sv
// Lock wait timer: counts a number of fixed-length units after a start pulse.
// Assumes start is a one-cycle pulse; a new start restarts the wait.
`timescale 1ns/100ps
module amlt_lock_timer #(
  parameter int unsigned UNIT_CYCLES = amlt_pkg::LOCK_UNIT_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       start,
  input  wire logic [7:0] units,
  // Result.
  output logic            busy,
  output logic            done
);

  localparam int unsigned PW = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYCLES - 1);

  logic [PW-1:0] pre_q;
  logic [7:0]    units_q;
  logic          busy_q;
  logic          done_q;

  initial begin
    if (UNIT_CYCLES < 1) begin
      $error("UNIT_CYCLES must be at least one");
    end
  end

  // Each unit is a full prescaler period, so done rises one cycle after units times the unit length.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q   <= '0;
      units_q <= 8'h00;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else if (start) begin
      pre_q   <= '0;
      units_q <= units;
      busy_q  <= 1'b1;
      done_q  <= 1'b0;
    end else if (busy_q) begin
      if (units_q == 8'h00) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end else if (pre_q == PRE_LAST) begin
        pre_q   <= '0;
        units_q <= units_q - 8'h01;
      end else begin
        pre_q <= pre_q + PW'(1);
      end
    end else begin
      done_q <= 1'b0;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule

// File: amlt_pkg.sv
// Constants for the address-match and lock-time configuration block.
// Assumes an APB master with 32-bit data; each register index maps to byte address index*4.
//
// Contract
// - Fix pointer zero skips all fixes; otherwise fixes start at that low-byte address.
// - Each fix entry is two bytes: modem register low address, then its data.
// - Fixes stop when the next entry's address byte is zero.
// - An 8-bit offset locates the first address byte in packet memory.
// - An 8-bit first-field length; zero disables address matching.
// - The table holds match then mask byte for each address byte, byte 0 first.
// - After the last pair comes zero to end, or the second field length and pairs.
// - With custom lock enabled, receive entry waits the programmed receive count.
// - With custom lock enabled, transmit entry waits the programmed transmit count.
// - The custom lock wait starts only after oscillator calibration completes.
// - Each lock count unit is a 2 us wait.
// - Entering sleep clears all modem configuration memory to defaults.
package amlt_pkg;

  // Register indices; byte address on the bus is four times the index.
  localparam logic [9:0] IDX_FIX_POINTER   = 10'h128;
  localparam logic [9:0] IDX_ADDR_OFFSET   = 10'h129;
  localparam logic [9:0] IDX_ADDR_LENGTH   = 10'h12A;
  localparam logic [9:0] IDX_TABLE_FIRST   = 10'h12B;
  localparam logic [9:0] IDX_TABLE_LAST    = 10'h13D;
  localparam logic [9:0] IDX_RX_LOCK_COUNT = 10'h13E;
  localparam logic [9:0] IDX_TX_LOCK_COUNT = 10'h13F;
  localparam logic [9:0] IDX_CONTROL       = 10'h140;
  localparam logic [9:0] IDX_STATUS        = 10'h141;
  localparam logic [9:0] IDX_MCM_BASE      = 10'h200;
  localparam logic [9:0] IDX_MCM_LAST      = 10'h2FF;

  // Battery-backed region layout, counted from the fix pointer register.
  localparam int unsigned BB_DEPTH         = 24;
  localparam int unsigned BB_POS_OFFSET    = 1;
  localparam int unsigned BB_POS_LENGTH    = 2;
  localparam int unsigned BB_POS_TABLE     = 3;
  localparam int unsigned BB_POS_RX_LOCK   = 22;
  localparam int unsigned BB_POS_TX_LOCK   = 23;
  localparam int unsigned TABLE_DEPTH      = 19;
  localparam logic [7:0]  BB_BASE_LOW      = 8'h28;
  localparam logic [7:0]  FIX_DISABLED     = 8'h00;
  localparam logic [7:0]  FIX_END_MARK     = 8'h00;
  localparam logic [7:0]  MATCH_OFF_LENGTH = 8'h00;

  // Reset values.
  localparam logic [7:0]  BB_RESET         = 8'h00;
  localparam logic [7:0]  MCM_RESET        = 8'h00;
  localparam logic [1:0]  CONTROL_RESET    = 2'h0;

  // Control and status field positions.
  localparam int unsigned CTRL_LOCK_EN_BIT = 0;
  localparam int unsigned CTRL_SLEEP_BIT   = 1;
  localparam int unsigned STAT_FIX_BUSY    = 0;
  localparam int unsigned STAT_SLEEP       = 1;
  localparam int unsigned STAT_LOCKED      = 2;
  localparam int unsigned STAT_MATCH_DONE  = 3;
  localparam int unsigned STAT_MATCH_OK    = 4;
  localparam int unsigned STAT_LOCK_TX     = 5;

  // Lock-time unit: a least time, so the cycle count rounds up.
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned LOCK_UNIT_NS     = 2000;
  localparam int unsigned LOCK_UNIT_CYCLES = (LOCK_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  DEFAULT_LOCK_UNITS = 8'h20;

endpackage

// File: amlt_top.sv
// Battery-backed configuration bank with static fixes, address matching and lock timing.
// Assumes an APB master on CORE_CLK and packet bytes presented with their packet positions.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module amlt_top #(
  parameter int unsigned MCM_DEPTH = 256
) (
  // Clock and reset.
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Received packet bytes.
  input  wire logic        PKT_START,
  input  wire logic        PKT_VALID,
  input  wire logic [7:0]  PKT_POS,
  input  wire logic [7:0]  PKT_BYTE,
  input  wire logic        PKT_LAST,
  output logic             MATCH_DONE,
  output logic             MATCH_OK,
  // Mode transitions and synthesizer.
  input  wire logic        RX_ENTER,
  input  wire logic        TX_ENTER,
  input  wire logic        CAL_DONE,
  output logic             SYNTH_LOCKED,
  output logic             LOCK_MODE_TX,
  // Modem configuration read port and fix status.
  input  wire logic [7:0]  MCM_RD_ADDR,
  output logic      [7:0]  MCM_RD_DATA,
  output logic             FIX_BUSY
);

  typedef enum logic [1:0] {FX_IDLE, FX_ADDR, FX_DATA} amlt_fix_type;
  typedef enum logic [1:0] {LK_IDLE, LK_CAL, LK_WAIT, LK_LOCKED} amlt_lock_type;

  initial begin
    if (MCM_DEPTH != 256) begin
      $error("MCM_DEPTH must be 256 to cover an 8-bit modem register address");
    end
  end

  logic [7:0]   bb_q [amlt_pkg::BB_DEPTH];
  logic [7:0]   mcm_q [MCM_DEPTH];
  logic [1:0]   ctrl_q;
  logic         sleep_prev_q;
  logic         fix_kick_q;
  amlt_fix_type fix_state_q;
  logic [5:0]   fix_pos_q;
  logic [7:0]   fix_addr_q;
  amlt_lock_type lock_state_q;
  logic         lock_tx_q;
  logic         pready_q;
  logic         pslverr_q;
  logic [31:0]  prdata_q;
  logic         match_done_q;
  logic         match_ok_q;
  logic         mismatch_q;
  logic [7:0]   checked_q;
  logic [7:0]   mcm_rd_q;

  // Bus decode shared by the read and write paths.
  logic [9:0]   bus_idx;
  logic         bus_access;
  logic         bus_wr;
  assign bus_idx    = PADDR[11:2];
  assign bus_access = PSEL && PENABLE && pready_q;
  assign bus_wr     = bus_access && PWRITE && (PADDR[1:0] == 2'b00);

  // True for indices that fall inside the battery-backed region.
  function automatic logic is_bb(input logic [9:0] idx);
    is_bb = (idx >= amlt_pkg::IDX_FIX_POINTER) && (idx <= amlt_pkg::IDX_TX_LOCK_COUNT);
  endfunction

  // True for indices that fall inside the modem configuration window.
  function automatic logic is_mcm(input logic [9:0] idx);
    is_mcm = (idx >= amlt_pkg::IDX_MCM_BASE) && (idx <= amlt_pkg::IDX_MCM_LAST);
  endfunction

  // Match-table byte by table position; positions past the table read as zero.
  function automatic logic [7:0] tbl(input logic [8:0] pos);
    if (pos < 9'(amlt_pkg::TABLE_DEPTH)) begin
      tbl = bb_q[amlt_pkg::BB_POS_TABLE + 32'(pos)];
    end else begin
      tbl = 8'h00;
    end
  endfunction

  // A received byte agrees when every bit picked by the mask equals the match byte.
  function automatic logic byte_agrees(input logic [7:0] rx, input logic [7:0] m, input logic [7:0] k);
    byte_agrees = ((rx ^ m) & k) == 8'h00;
  endfunction

  // Bus handshake: one wait state; read data is captured on the edge that raises PREADY, and the write lands one edge later.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= PSEL && PENABLE && !pready_q;
    end
  end

  // Read data and error are captured as PREADY rises and stand while it is high.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (PSEL && PENABLE && !pready_q) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      if (PADDR[1:0] != 2'b00) begin
        pslverr_q <= 1'b1;
      end else if (is_bb(bus_idx)) begin
        prdata_q <= {24'h00_0000, bb_q[32'(bus_idx - amlt_pkg::IDX_FIX_POINTER)]};
      end else if (bus_idx == amlt_pkg::IDX_CONTROL) begin
        prdata_q <= {30'h0000_0000, ctrl_q};
      end else if (bus_idx == amlt_pkg::IDX_STATUS) begin
        prdata_q <= {26'h000_0000, lock_tx_q, match_ok_q, match_done_q,
                     lock_state_q == LK_LOCKED, ctrl_q[amlt_pkg::CTRL_SLEEP_BIT],
                     fix_state_q != FX_IDLE};
      end else if (is_mcm(bus_idx)) begin
        prdata_q <= {24'h00_0000, mcm_q[32'(bus_idx - amlt_pkg::IDX_MCM_BASE)]};
      end else begin
        pslverr_q <= 1'b1;
      end
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Battery-backed bytes survive sleep; only the bus writes them.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < amlt_pkg::BB_DEPTH; i++) begin
        bb_q[i] <= amlt_pkg::BB_RESET;
      end
    end else if (bus_wr && is_bb(bus_idx)) begin
      bb_q[32'(bus_idx - amlt_pkg::IDX_FIX_POINTER)] <= PWDATA[7:0];
    end
  end

  // Control register: custom lock enable and sleep request.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ctrl_q <= amlt_pkg::CONTROL_RESET;
    end else if (bus_wr && (bus_idx == amlt_pkg::IDX_CONTROL)) begin
      ctrl_q <= PWDATA[1:0];
    end
  end

  // Leaving sleep, or leaving reset, asks the fix engine to reapply its entries.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sleep_prev_q <= 1'b0;
      fix_kick_q   <= 1'b1;
    end else begin
      sleep_prev_q <= ctrl_q[amlt_pkg::CTRL_SLEEP_BIT];
      fix_kick_q   <= sleep_prev_q && !ctrl_q[amlt_pkg::CTRL_SLEEP_BIT];
    end
  end

  // Static fix engine walks address/data pairs from the pointed-to battery-backed byte.
  logic [7:0] fix_ptr;
  logic [7:0] fix_byte;
  assign fix_ptr  = bb_q[0];
  assign fix_byte = (32'(fix_pos_q) < amlt_pkg::BB_DEPTH) ? bb_q[32'(fix_pos_q)] : amlt_pkg::FIX_END_MARK;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      fix_state_q <= FX_IDLE;
      fix_pos_q   <= 6'h00;
      fix_addr_q  <= 8'h00;
    end else begin
      case (fix_state_q)
        FX_IDLE: begin
          if (fix_kick_q && (fix_ptr != amlt_pkg::FIX_DISABLED)) begin
            fix_pos_q   <= 6'(fix_ptr - amlt_pkg::BB_BASE_LOW);
            fix_state_q <= FX_ADDR;
          end
        end
        FX_ADDR: begin
          if (ctrl_q[amlt_pkg::CTRL_SLEEP_BIT] || (fix_byte == amlt_pkg::FIX_END_MARK)) begin
            fix_state_q <= FX_IDLE;
          end else begin
            fix_addr_q  <= fix_byte;
            fix_pos_q   <= fix_pos_q + 6'h01;
            fix_state_q <= FX_DATA;
          end
        end
        FX_DATA: begin
          fix_pos_q   <= fix_pos_q + 6'h01;
          fix_state_q <= ctrl_q[amlt_pkg::CTRL_SLEEP_BIT] ? FX_IDLE : FX_ADDR;
        end
        default: begin
          fix_state_q <= FX_IDLE;
        end
      endcase
    end
  end

  // Modem configuration memory: sleep wipes it, then fixes, then bus writes.
  // Bus writes during a fix are dropped so that the fixed value is the one that stays.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || ctrl_q[amlt_pkg::CTRL_SLEEP_BIT]) begin
      for (int i = 0; i < MCM_DEPTH; i++) begin
        mcm_q[i] <= amlt_pkg::MCM_RESET;
      end
    end else if (fix_state_q == FX_DATA) begin
      mcm_q[fix_addr_q] <= fix_byte;
    end else if (bus_wr && is_mcm(bus_idx) && (fix_state_q == FX_IDLE)) begin
      mcm_q[bus_idx[7:0]] <= PWDATA[7:0];
    end
  end

  // Registered read port for the modem datapath.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      mcm_rd_q <= amlt_pkg::MCM_RESET;
    end else begin
      mcm_rd_q <= mcm_q[MCM_RD_ADDR];
    end
  end

  // Address match decode for the byte now on the packet port.
  logic [7:0] n1;
  logic [7:0] n2;
  logic [7:0] rel;
  logic [8:0] pair_pos;
  logic       in_field;
  logic       byte_bad;
  assign n1  = bb_q[amlt_pkg::BB_POS_LENGTH];
  assign n2  = tbl({n1, 1'b0});
  assign rel = PKT_POS - bb_q[amlt_pkg::BB_POS_OFFSET];

  always_comb begin
    pair_pos = 9'h000;
    in_field = 1'b0;
    if (PKT_POS >= bb_q[amlt_pkg::BB_POS_OFFSET]) begin
      if (rel < n1) begin
        pair_pos = {rel, 1'b0};
        in_field = 1'b1;
      end else if ({1'b0, rel} < ({1'b0, n1} + {1'b0, n2})) begin
        pair_pos = {n1, 1'b0} + 9'h001 + {rel - n1, 1'b0};
        in_field = 1'b1;
      end
    end
  end

  // Positions beyond the table cannot hold a pair and so never match.
  assign byte_bad = in_field && ((pair_pos + 9'h001) >= 9'(amlt_pkg::TABLE_DEPTH)
                    || !byte_agrees(PKT_BYTE, tbl(pair_pos), tbl(pair_pos + 9'h001)));

  // Match tracking over one packet; the result stands until the next packet starts.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || PKT_START) begin
      mismatch_q   <= 1'b0;
      checked_q    <= 8'h00;
      match_done_q <= 1'b0;
      match_ok_q   <= 1'b0;
    end else if (PKT_VALID && !match_done_q) begin
      mismatch_q <= mismatch_q || byte_bad;
      checked_q  <= checked_q + {7'h00, in_field};
      if (PKT_LAST) begin
        match_done_q <= 1'b1;
        if (n1 == amlt_pkg::MATCH_OFF_LENGTH) begin
          match_ok_q <= 1'b1;
        end else begin
          match_ok_q <= !mismatch_q && !byte_bad
                        && (({1'b0, checked_q} + {8'h00, in_field}) == ({1'b0, n1} + {1'b0, n2}));
        end
      end
    end
  end

  // Lock wait timer shared by receive and transmit entries.
  logic       tmr_start;
  logic       tmr_done;
  logic [7:0] tmr_units;
  assign tmr_start = (lock_state_q == LK_CAL) && CAL_DONE;
  assign tmr_units = !ctrl_q[amlt_pkg::CTRL_LOCK_EN_BIT] ? amlt_pkg::DEFAULT_LOCK_UNITS
                   : lock_tx_q ? bb_q[amlt_pkg::BB_POS_TX_LOCK]
                   : bb_q[amlt_pkg::BB_POS_RX_LOCK];

  amlt_lock_timer #(
    .UNIT_CYCLES (amlt_pkg::LOCK_UNIT_CYCLES)
  ) u_lock_timer (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .start (tmr_start),
    .units (tmr_units),
    .busy  (),
    .done  (tmr_done)
  );

  // Lock sequence: wait for calibration, then the lock wait, then report lock.
  // A new mode entry at any point outside sleep restarts the sequence; transmit wins a tie.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lock_state_q <= LK_IDLE;
      lock_tx_q    <= 1'b0;
    end else if (ctrl_q[amlt_pkg::CTRL_SLEEP_BIT]) begin
      lock_state_q <= LK_IDLE;
    end else if (RX_ENTER || TX_ENTER) begin
      lock_state_q <= LK_CAL;
      lock_tx_q    <= TX_ENTER;
    end else begin
      case (lock_state_q)
        LK_CAL: begin
          if (CAL_DONE) begin
            lock_state_q <= LK_WAIT;
          end
        end
        LK_WAIT: begin
          if (tmr_done) begin
            lock_state_q <= LK_LOCKED;
          end
        end
        default: begin
          lock_state_q <= lock_state_q;
        end
      endcase
    end
  end

  // Synthesizer lock flag registered separately so the output comes from a flip-flop.
  logic locked_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= (lock_state_q == LK_WAIT && tmr_done)
                  || (lock_state_q == LK_LOCKED && !RX_ENTER && !TX_ENTER
                      && !ctrl_q[amlt_pkg::CTRL_SLEEP_BIT]);
    end
  end

  // Fix busy flag, one cycle behind the engine state.
  logic fix_busy_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      fix_busy_q <= 1'b0;
    end else begin
      fix_busy_q <= fix_state_q != FX_IDLE;
    end
  end

  // Outputs, each driven by a flip-flop.
  assign PRDATA       = prdata_q;
  assign PREADY       = pready_q;
  assign PSLVERR      = pslverr_q;
  assign MATCH_DONE   = match_done_q;
  assign MATCH_OK     = match_ok_q;
  assign SYNTH_LOCKED = locked_q;
  assign LOCK_MODE_TX = lock_tx_q;
  assign MCM_RD_DATA  = mcm_rd_q;
  assign FIX_BUSY     = fix_busy_q;

endmodule

// File: tb_addr_match_and_lock_time_cfg.sv
// Self-checking bench for the configuration bank with an integer model of registers and memory.
// Assumes amlt_top with one bus wait state and 200 cycles per lock unit.
`timescale 1ns/100ps
module tb_addr_match_and_lock_time_cfg;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, sl;
  logic        pkt_start, pkt_valid, pkt_last, match_done, match_ok, hit, ok;
  logic        rx_enter, tx_enter, cal_done, synth_locked, lock_mode_tx, fix_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pkt_pos, pkt_byte, mcm_rd_addr, mcm_rd_data, v;
  logic [7:0]  fx [7];
  int          bad_count, samples_checked, i, t, p, q, off, n1, n2, m, n, units, dummy;
  int          bb [24];
  int          mcm [256];

  amlt_top #(.MCM_DEPTH(256)) dut_u (
    .CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PKT_START(pkt_start), .PKT_VALID(pkt_valid), .PKT_POS(pkt_pos), .PKT_BYTE(pkt_byte),
    .PKT_LAST(pkt_last), .MATCH_DONE(match_done), .MATCH_OK(match_ok), .RX_ENTER(rx_enter),
    .TX_ENTER(tx_enter), .CAL_DONE(cal_done), .SYNTH_LOCKED(synth_locked),
    .LOCK_MODE_TX(lock_mode_tx), .MCM_RD_ADDR(mcm_rd_addr), .MCM_RD_DATA(mcm_rd_data),
    .FIX_BUSY(fix_busy)
  );

  // Clock of 10 ns period.
  always #5 core_clk = ~core_clk;

  // Comparison of values, counted.
  task check_val(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Comparison of single flags, counted.
  task check_flag(input logic e, input logic g);
    check_val({31'h0, e}, {31'h0, g});
  endtask

  // One bus transfer; the wait is bounded so a silent slave cannot hang the run.
  task apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) bad_count++;
  endtask

  // Replays the fix list into the model memory.
  function void run_fixes();
    int k;
    if (bb[0] == 0) return;
    k = bb[0] - 'h28;
    while (k < 23 && bb[k] != 0) begin
      mcm[bb[k]] = bb[k + 1];
      k += 2;
    end
  endfunction

  // Write through the bus and mirror the effect in the model; waits out any fix run.
  task wr(input logic [9:0] idx, input logic [7:0] d);
    logic exp_busy;
    apb(1'b1, idx, d);
    if (idx >= 10'h128 && idx <= 10'h13F) bb[idx - 10'h128] = d;
    if (idx >= 10'h200) mcm[idx[7:0]] = d;
    if (idx == 10'h140) begin
      // A wake with a nonzero pointer must show the fix engine running four edges later.
      exp_busy = !d[1] && sl && bb[0] != 0;
      if (d[1]) foreach (mcm[k]) mcm[k] = 0;
      else if (sl) run_fixes();
      sl = d[1];
      repeat (4) @(posedge core_clk);
      check_flag(exp_busy, fix_busy);
      for (m = 0; m < 100 && fix_busy !== 1'b0; m++) @(posedge core_clk);
    end
  endtask

  task rdchk(input logic [9:0] idx, input int e);
    apb(1'b0, idx, 8'h00);
    check_val(e, rd);
  endtask

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog sized well above the expected run of about ten thousand cycles.
  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    core_clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pkt_start = 0; pkt_valid = 0; pkt_last = 0; pkt_pos = 0; pkt_byte = 0;
    rx_enter = 0; tx_enter = 0; cal_done = 0; mcm_rd_addr = 0; sl = 0;
    bad_count = 0; samples_checked = 0;
    foreach (bb[k]) bb[k] = 0;
    foreach (mcm[k]) mcm[k] = 0;
    fx = '{8'h5E, 8'h46, 8'h5F, 8'h78, 8'h00, 8'h60, 8'h99};
    dummy = $urandom(97);
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values, random readback and an unmapped place.
    for (i = 'h128; i <= 'h13F; i++) rdchk(i[9:0], amlt_pkg::BB_RESET);
    for (i = 'h129; i <= 'h13F; i++) wr(i[9:0], 8'($urandom));
    for (i = 'h129; i <= 'h13F; i++) rdchk(i[9:0], bb[i - 'h128]);
    apb(1'b0, 10'h010, 8'h00);
    check_flag(1'b1, err);
    $display("test registers done");
    // Fix list with an entry past the end mark, applied on wake from sleep.
    for (i = 0; i < 7; i++) wr(10'h12B + 10'(i), fx[i]);
    wr(10'h128, 8'h2B);
    wr(10'h210, 8'hAA);
    rdchk(10'h210, 'hAA);
    wr(10'h140, 8'h02);
    rdchk(10'h210, 0);
    wr(10'h140, 8'h00);
    rdchk(10'h25E, mcm['h5E]);
    rdchk(10'h25F, mcm['h5F]);
    rdchk(10'h260, mcm['h60]);
    rdchk(10'h210, 0);
    @(posedge core_clk);
    mcm_rd_addr <= 8'h5F;
    repeat (2) @(posedge core_clk);
    check_val(mcm['h5F], {24'h000000, mcm_rd_data});
    wr(10'h128, 8'h00);
    wr(10'h140, 8'h02);
    wr(10'h140, 8'h00);
    rdchk(10'h25E, 0);
    $display("test fixes done");
    // Address matching with random offsets, lengths, masks and hits.
    for (t = 0; t < 8; t++) begin
      off = $urandom_range(0, 15);
      n1 = (t == 0) ? 0 : $urandom_range(1, 3);
      n2 = $urandom_range(0, 2);
      hit = (t < 5) ? 1'b1 : 1'($urandom);
      wr(10'h129, 8'(off));
      wr(10'h12A, 8'(n1));
      for (i = 0; i < 19; i++) wr(10'h12B + 10'(i), (i == 2 * n1) ? 8'(n2) : 8'($urandom));
      ok = 1'b1;
      @(posedge core_clk);
      pkt_start <= 1'b1;
      for (p = 0; p <= off + n1 + n2; p++) begin
        @(posedge core_clk);
        v = 8'($urandom);
        q = (p - off < n1) ? 2 * (p - off) : 2 * (p - off) + 1;
        if (p >= off && p < off + n1 + n2) begin
          if (hit) v = 8'((bb[3 + q] & bb[4 + q]) | (v & ~bb[4 + q]));
          if (n1 != 0 && ((v ^ bb[3 + q]) & bb[4 + q]) != 0) ok = 1'b0;
        end
        pkt_start <= 1'b0; pkt_valid <= 1'b1; pkt_pos <= 8'(p); pkt_byte <= v;
        pkt_last <= (p == off + n1 + n2);
      end
      @(posedge core_clk);
      pkt_valid <= 1'b0; pkt_last <= 1'b0;
      @(posedge core_clk);
      check_flag(1'b1, match_done);
      check_flag(ok, match_ok);
    end
    $display("test matching done");
    // Lock waits: receive and transmit counts, then the default with custom timing off.
    wr(10'h13E, 8'h01);
    wr(10'h13F, 8'h02);
    for (t = 0; t < 3; t++) begin
      wr(10'h140, (t < 2) ? 8'h01 : 8'h00);
      units = (t == 0) ? 1 : (t == 1) ? 2 : int'(amlt_pkg::DEFAULT_LOCK_UNITS);
      @(posedge core_clk);
      rx_enter <= (t != 1); tx_enter <= (t == 1);
      @(posedge core_clk);
      rx_enter <= 1'b0; tx_enter <= 1'b0;
      repeat (300) @(posedge core_clk);
      check_flag(1'b0, synth_locked);
      cal_done <= 1'b1;
      @(posedge core_clk);
      cal_done <= 1'b0;
      for (n = 1; synth_locked !== 1'b1 && n < 7000; n++) @(posedge core_clk);
      check_flag(1'b1, n >= units * 200 && n <= units * 200 + 8);
      check_flag(t == 1, lock_mode_tx);
    end
    // Control reads back cleared; status shows lock held, receive mode and the last match result.
    rdchk(10'h140, 0);
    rdchk(10'h141, {ok, 4'hC});
    $display("test lock done");
    report_and_stop();
  end
endmodule
